/* File: hw/i2c_ctrl_pkg.sv */
package i2c_ctrl_pkg;
  // bus address and direction
  localparam logic [6:0] DEV_ADDR = 7'h00;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [7:0] NULL_BYTE = 8'h00;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // strap levels that pick the two-wire mode
  localparam logic RD_STRAP_I2C = 1'b0;
  localparam logic WR_STRAP_I2C = 1'b1;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // synchroniser reset values: {scl, sda, rd, wr, req} and {sda, attn}
  localparam logic [4:0] LINK_SYNC_INIT = 5'h1a;
  localparam logic [1:0] HOST_SYNC_INIT = 2'h3;
  // host serial clock timing, one slot is four quarters
  localparam int MCLK_NS = 25;
  localparam int QUARTER_NS = 500;
  localparam int QUARTER_CYC = (QUARTER_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [4:0] QUARTER_LAST = 5'(QUARTER_CYC - 1);
  localparam logic [1:0] Q_FIRST = 2'h0;
  localparam logic [1:0] Q_SDA = 2'h1;
  localparam logic [1:0] Q_RISE = 2'h2;
  localparam logic [1:0] Q_LAST = 2'h3;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_ADDR = 3'h1,
    D_AACK = 3'h2,
    D_WDATA = 3'h3,
    D_WACK = 3'h4,
    D_RDATA = 3'h5,
    D_RACK = 3'h6
  } dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_START = 3'h1,
    H_TX = 3'h2,
    H_TACK = 3'h3,
    H_WAIT = 3'h4,
    H_RX = 3'h5,
    H_RACK = 3'h6,
    H_STOP = 3'h7
  } host_state_e;
endpackage : i2c_ctrl_pkg

/* File: hw/i2c_link_if.sv */
`timescale 1ns/1ps
interface i2c_link_if;
  logic ctrl_serial_clock;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic ctrl_serial_data_io;
  logic host_attention_n;
  logic rd_strap_n;
  logic wr_strap_n;

  // open-drain wire with pull-up
  assign ctrl_serial_data_io = ~((host_sda_oe & ~host_sda_o) |
                                 (dev_sda_oe & ~dev_sda_o));

  modport device_mp (
    input ctrl_serial_clock,
    input ctrl_serial_data_io,
    input rd_strap_n,
    input wr_strap_n,
    output dev_sda_o,
    output dev_sda_oe,
    output host_attention_n
  );

  modport host_mp (
    output ctrl_serial_clock,
    input ctrl_serial_data_io,
    input host_attention_n,
    output host_sda_o,
    output host_sda_oe,
    output rd_strap_n,
    output wr_strap_n
  );
endinterface : i2c_link_if

/* File: hw/sync2.sv */
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s r_reg;
  sync_s r_next;

  // first stage feeds only the second
  always_comb
  begin
    r_next.meta = d_i;
    r_next.stable = r_reg.meta;
  end

  // two-flop chain
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      r_reg.meta <= INIT;
      r_reg.stable <= INIT;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.stable;
endmodule : sync2

/* File: hw/i2c_dev_port.sv */
`timescale 1ns/1ps
module i2c_dev_port (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic link_clk_i,
  i2c_link_if.device_mp link,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o
);
  typedef struct packed {
    i2c_ctrl_pkg::dev_state_e st;
    logic scl_q;
    logic sda_q;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic got8;
    logic rw;
    logic hack;
    logic oe;
    logic attn_n;
    logic rose;
    logic null_pend;
    logic [7:0] pend;
    logic pend_v;
    logic req_q;
    logic ack_tgl;
    logic [7:0] wr_byte;
    logic wr_tgl;
    logic [1:0] settle;
    logic mode_done;
    logic mode;
  } link_s;

  typedef struct packed {
    logic [7:0] hold;
    logic req;
    logic busy;
    logic ack_q;
    logic wr_q;
    logic [7:0] rx_data;
    logic rx_valid;
  } core_s;

  link_s lk_reg;
  link_s lk_next;
  core_s co_reg;
  core_s co_next;
  logic link_rstn;
  logic [4:0] lsync;
  logic [1:0] csync;
  logic scl_s;
  logic sda_s;
  logic rd_s;
  logic wr_s;
  logic req_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // next byte to shift out: null first after a late message
  function automatic link_s load_tx(input link_s s);
    link_s o;
    o = s;
    if (s.null_pend)
    begin
      o.sh = i2c_ctrl_pkg::NULL_BYTE;
      o.null_pend = 1'b0;
    end
    else if (s.pend_v)
    begin
      o.sh = s.pend;
      o.pend_v = 1'b0;
    end
    else
    begin
      o.sh = i2c_ctrl_pkg::NULL_BYTE;
    end
    o.oe = ~o.sh[7];
    return o;
  endfunction : load_tx

  // link-domain reset release
  sync2 #(.W(1), .INIT(1'b0)) u_rst_sync (
    .clk_i(link_clk_i),
    .rstn_i(1'b1),
    .d_i(rstn_i),
    .q_o(link_rstn)
  );

  // pins and core request into the link domain
  sync2 #(.W(5), .INIT(i2c_ctrl_pkg::LINK_SYNC_INIT)) u_link_sync (
    .clk_i(link_clk_i),
    .rstn_i(link_rstn),
    .d_i({link.ctrl_serial_clock, link.ctrl_serial_data_io,
          link.rd_strap_n, link.wr_strap_n, co_reg.req}),
    .q_o(lsync)
  );

  // link toggles into the core domain
  sync2 #(.W(2), .INIT(2'h0)) u_core_sync (
    .clk_i(mclk_i),
    .rstn_i(rstn_i),
    .d_i({lk_reg.ack_tgl, lk_reg.wr_tgl}),
    .q_o(csync)
  );

  // bus events from synchronised samples
  assign {scl_s, sda_s, rd_s, wr_s, req_s} = lsync;
  assign rise = scl_s & ~lk_reg.scl_q;
  assign fall = ~scl_s & lk_reg.scl_q;
  assign start = scl_s & lk_reg.scl_q & lk_reg.sda_q & ~sda_s;
  assign stop = scl_s & lk_reg.scl_q & ~lk_reg.sda_q & sda_s;

  // link-side protocol engine
  always_comb
  begin
    lk_next = lk_reg;
    lk_next.scl_q = scl_s;
    lk_next.sda_q = sda_s;
    if ((req_s != lk_reg.req_q) && !lk_reg.pend_v)
    begin
      lk_next.pend = co_reg.hold; // held stable while busy
      lk_next.pend_v = 1'b1;
      lk_next.req_q = req_s;
      lk_next.ack_tgl = ~lk_reg.ack_tgl;
    end
    if (lk_reg.settle != i2c_ctrl_pkg::STRAP_SETTLE)
    begin
      lk_next.settle = 2'(lk_reg.settle + 2'h1);
    end
    else if (!lk_reg.mode_done)
    begin
      lk_next.mode_done = 1'b1;
      lk_next.mode = (rd_s == i2c_ctrl_pkg::RD_STRAP_I2C) &&
                     (wr_s == i2c_ctrl_pkg::WR_STRAP_I2C);
    end
    if (stop)
    begin
      lk_next.st = i2c_ctrl_pkg::D_IDLE;
      lk_next.oe = 1'b0;
      lk_next.null_pend = 1'b0; // fresh read loads message directly
      lk_next.rose = 1'b0;
    end
    else if (start)
    begin
      lk_next.st = i2c_ctrl_pkg::D_ADDR;
      lk_next.cnt = i2c_ctrl_pkg::FIRST_BIT;
      lk_next.got8 = 1'b0;
      lk_next.oe = 1'b0;
    end
    else
    begin
      case (lk_reg.st)
        i2c_ctrl_pkg::D_ADDR, i2c_ctrl_pkg::D_WDATA:
        begin
          if (rise)
          begin
            lk_next.sh = {lk_reg.sh[6:0], sda_s};
            lk_next.got8 = (lk_reg.cnt == i2c_ctrl_pkg::LAST_BIT);
            lk_next.cnt = 3'(lk_reg.cnt + 3'h1);
          end
          else if (fall && lk_reg.got8)
          begin
            lk_next.got8 = 1'b0;
            if (lk_reg.st == i2c_ctrl_pkg::D_WDATA)
            begin
              lk_next.wr_byte = lk_reg.sh;
              lk_next.wr_tgl = ~lk_reg.wr_tgl;
              lk_next.oe = 1'b1;
              lk_next.st = i2c_ctrl_pkg::D_WACK;
            end
            else if (lk_reg.sh[7:1] == i2c_ctrl_pkg::DEV_ADDR)
            begin
              lk_next.rw = lk_reg.sh[0];
              lk_next.oe = 1'b1;
              lk_next.st = i2c_ctrl_pkg::D_AACK;
            end
            else
            begin
              lk_next.st = i2c_ctrl_pkg::D_IDLE;
            end
          end
        end
        i2c_ctrl_pkg::D_AACK:
        begin
          if (fall && (lk_reg.rw == i2c_ctrl_pkg::RW_READ))
          begin
            lk_next = load_tx(lk_next);
            lk_next.st = i2c_ctrl_pkg::D_RDATA;
            lk_next.cnt = i2c_ctrl_pkg::FIRST_BIT;
          end
          else if (fall)
          begin
            lk_next.oe = 1'b0;
            lk_next.st = i2c_ctrl_pkg::D_WDATA;
            lk_next.cnt = i2c_ctrl_pkg::FIRST_BIT;
          end
        end
        i2c_ctrl_pkg::D_WACK:
        begin
          if (fall)
          begin
            lk_next.oe = 1'b0;
            lk_next.st = i2c_ctrl_pkg::D_WDATA;
            lk_next.cnt = i2c_ctrl_pkg::FIRST_BIT;
          end
        end
        i2c_ctrl_pkg::D_RDATA:
        begin
          if (rise)
          begin
            lk_next.cnt = 3'(lk_reg.cnt + 3'h1);
            if (lk_reg.cnt == i2c_ctrl_pkg::LAST_BIT)
            begin
              lk_next.got8 = 1'b1;
              if (!lk_next.pend_v)
              begin
                lk_next.attn_n = 1'b1;
                lk_next.rose = 1'b1;
              end
            end
          end
          else if (fall && lk_reg.got8)
          begin
            lk_next.got8 = 1'b0;
            lk_next.oe = 1'b0;
            lk_next.st = i2c_ctrl_pkg::D_RACK;
          end
          else if (fall)
          begin
            lk_next.sh = lk_reg.sh << 1;
            lk_next.oe = ~lk_reg.sh[6];
          end
        end
        i2c_ctrl_pkg::D_RACK:
        begin
          if (rise)
          begin
            lk_next.hack = ~sda_s;
            lk_next.rose = 1'b0;
            if (lk_reg.rose && lk_next.pend_v)
            begin
              lk_next.attn_n = 1'b0;
              lk_next.null_pend = 1'b1;
            end
          end
          else if (fall && lk_reg.hack)
          begin
            lk_next = load_tx(lk_next);
            lk_next.st = i2c_ctrl_pkg::D_RDATA;
            lk_next.cnt = i2c_ctrl_pkg::FIRST_BIT;
          end
          else if (fall)
          begin
            lk_next.st = i2c_ctrl_pkg::D_IDLE;
          end
        end
        default:
        begin
          lk_next.oe = 1'b0;
        end
      endcase
    end
    if (lk_next.pend_v && !lk_next.rose)
    begin
      lk_next.attn_n = 1'b0;
    end
    if (!lk_next.mode)
    begin
      lk_next.st = i2c_ctrl_pkg::D_IDLE;
      lk_next.oe = 1'b0;
      lk_next.attn_n = 1'b1;
    end
  end

  // link-domain state
  always_ff @(posedge link_clk_i)
  begin
    if (!link_rstn)
    begin
      lk_reg <= '0;
      lk_reg.st <= i2c_ctrl_pkg::D_IDLE;
      lk_reg.scl_q <= 1'b1;
      lk_reg.sda_q <= 1'b1;
      lk_reg.attn_n <= 1'b1;
    end
    else
    begin
      lk_reg <= lk_next;
    end
  end

  // core side: toggle handshake for tx, toggle edge for rx
  always_comb
  begin
    co_next = co_reg;
    co_next.rx_valid = 1'b0;
    if (csync[1] != co_reg.ack_q)
    begin
      co_next.ack_q = csync[1];
      co_next.busy = 1'b0;
    end
    if (tx_valid_i && !co_reg.busy)
    begin
      co_next.hold = tx_data_i;
      co_next.req = ~co_reg.req;
      co_next.busy = 1'b1;
    end
    if (csync[0] != co_reg.wr_q)
    begin
      co_next.wr_q = csync[0];
      co_next.rx_data = lk_reg.wr_byte; // stable for a whole byte time
      co_next.rx_valid = 1'b1;
    end
  end

  // core-domain state
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      co_reg <= '0;
    end
    else
    begin
      co_reg <= co_next;
    end
  end

  assign tx_ready_o = ~co_reg.busy;
  assign rx_data_o = co_reg.rx_data;
  assign rx_valid_o = co_reg.rx_valid;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = lk_reg.oe;
  assign link.host_attention_n = lk_reg.attn_n;
endmodule : i2c_dev_port

/* File: hw/i2c_host_port.sv */
`timescale 1ns/1ps
module i2c_host_port (
  input wire logic mclk_i,
  input wire logic rstn_i,
  i2c_link_if.host_mp link,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_last_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic dev_reset_o
);
  typedef struct packed {
    i2c_ctrl_pkg::host_state_e st;
    logic [1:0] q;
    logic [4:0] qcnt;
    logic [2:0] bitc;
    logic [7:0] cur;
    logic [7:0] hold;
    logic last;
    logic is_read;
    logic in_data;
    logic retried;
    logic keep;
    logic first;
    logic scl;
    logic sda_oe;
    logic [7:0] rd_data;
    logic rd_valid;
    logic dev_reset;
  } host_s;

  host_s r_reg;
  host_s r_next;
  logic [1:0] hsync;
  logic sda_s;
  logic attn_s;

  // data and attention pins into the core clock
  sync2 #(.W(2), .INIT(i2c_ctrl_pkg::HOST_SYNC_INIT)) u_pin_sync (
    .clk_i(mclk_i),
    .rstn_i(rstn_i),
    .d_i({link.ctrl_serial_data_io, link.host_attention_n}),
    .q_o(hsync)
  );
  assign {sda_s, attn_s} = hsync;

  // slot sequencer, clock low q0-q1 and high q2-q3, except in the start slot where it stays high in all four
  always_comb
  begin
    r_next = r_reg;
    r_next.rd_valid = 1'b0;
    r_next.dev_reset = 1'b0;
    case (r_reg.st)
      i2c_ctrl_pkg::H_IDLE:
      begin
        r_next.q = i2c_ctrl_pkg::Q_FIRST;
        r_next.qcnt = 5'h00;
        r_next.retried = 1'b0;
        if (!attn_s)
        begin
          r_next.st = i2c_ctrl_pkg::H_START;
          r_next.cur = {i2c_ctrl_pkg::DEV_ADDR, i2c_ctrl_pkg::RW_READ};
          r_next.is_read = 1'b1;
          r_next.first = 1'b1;
        end
        else if (wr_valid_i)
        begin
          r_next.st = i2c_ctrl_pkg::H_START;
          r_next.cur = {i2c_ctrl_pkg::DEV_ADDR, i2c_ctrl_pkg::RW_WRITE};
          r_next.hold = wr_data_i;
          r_next.last = wr_last_i;
          r_next.is_read = 1'b0;
          r_next.in_data = 1'b0;
        end
      end
      i2c_ctrl_pkg::H_WAIT:
      begin
        if (wr_valid_i)
        begin
          r_next.st = i2c_ctrl_pkg::H_TX;
          r_next.cur = wr_data_i;
          r_next.last = wr_last_i;
          r_next.bitc = i2c_ctrl_pkg::FIRST_BIT;
          r_next.q = i2c_ctrl_pkg::Q_FIRST;
          r_next.qcnt = 5'h00;
        end
      end
      default:
      begin
        r_next.qcnt = 5'(r_reg.qcnt + 5'h01);
        if (r_reg.qcnt == i2c_ctrl_pkg::QUARTER_LAST)
        begin
          r_next.qcnt = 5'h00;
          r_next.q = 2'(r_reg.q + 2'h1);
        end
        if ((r_reg.qcnt == i2c_ctrl_pkg::QUARTER_LAST) &&
            (r_reg.q == i2c_ctrl_pkg::Q_LAST))
        begin
          case (r_reg.st)
            i2c_ctrl_pkg::H_START:
            begin
              r_next.st = i2c_ctrl_pkg::H_TX;
              r_next.bitc = i2c_ctrl_pkg::FIRST_BIT;
            end
            i2c_ctrl_pkg::H_TX:
            begin
              r_next.bitc = 3'(r_reg.bitc + 3'h1);
              if (r_reg.bitc == i2c_ctrl_pkg::LAST_BIT)
              begin
                r_next.st = i2c_ctrl_pkg::H_TACK;
              end
            end
            i2c_ctrl_pkg::H_TACK:
            begin
              r_next.bitc = i2c_ctrl_pkg::FIRST_BIT;
              if (sda_s && r_reg.is_read)
              begin
                r_next.st = i2c_ctrl_pkg::H_STOP;
              end
              else if (sda_s && !r_reg.retried)
              begin
                r_next.retried = 1'b1;
                r_next.st = i2c_ctrl_pkg::H_TX;
              end
              else if (sda_s)
              begin
                r_next.st = i2c_ctrl_pkg::H_STOP;
                r_next.dev_reset = 1'b1;
              end
              else
              begin
                r_next.retried = 1'b0;
                if (r_reg.is_read)
                begin
                  r_next.st = i2c_ctrl_pkg::H_RX;
                end
                else if (!r_reg.in_data)
                begin
                  r_next.in_data = 1'b1;
                  r_next.cur = r_reg.hold;
                  r_next.st = i2c_ctrl_pkg::H_TX;
                end
                else if (r_reg.last)
                begin
                  r_next.st = i2c_ctrl_pkg::H_STOP;
                end
                else
                begin
                  r_next.st = i2c_ctrl_pkg::H_WAIT;
                end
              end
            end
            i2c_ctrl_pkg::H_RX:
            begin
              r_next.cur = {r_reg.cur[6:0], sda_s};
              r_next.bitc = 3'(r_reg.bitc + 3'h1);
              if (r_reg.bitc == i2c_ctrl_pkg::LAST_BIT)
              begin
                r_next.keep = ~attn_s;
                r_next.st = i2c_ctrl_pkg::H_RACK;
              end
            end
            i2c_ctrl_pkg::H_RACK:
            begin
              r_next.first = 1'b0;
              if (!(r_reg.first && (r_reg.cur == i2c_ctrl_pkg::NULL_BYTE)))
              begin
                r_next.rd_data = r_reg.cur;
                r_next.rd_valid = 1'b1;
              end
              r_next.bitc = i2c_ctrl_pkg::FIRST_BIT;
              r_next.st = r_reg.keep ? i2c_ctrl_pkg::H_RX :
                                       i2c_ctrl_pkg::H_STOP;
            end
            default:
            begin
              r_next.st = i2c_ctrl_pkg::H_IDLE;
            end
          endcase
        end
      end
    endcase
    // pin drive for the coming cycle
    case (r_next.st)
      i2c_ctrl_pkg::H_IDLE:
      begin
        r_next.scl = 1'b1;
        r_next.sda_oe = 1'b0;
      end
      i2c_ctrl_pkg::H_START:
      begin
        r_next.scl = 1'b1;
        r_next.sda_oe = r_next.q[1];
      end
      i2c_ctrl_pkg::H_WAIT:
      begin
        r_next.scl = 1'b0;
      end
      default:
      begin
        r_next.scl = r_next.q[1];
        if (r_next.q == i2c_ctrl_pkg::Q_SDA)
        begin
          case (r_next.st)
            i2c_ctrl_pkg::H_TX:
              r_next.sda_oe = ~r_next.cur[3'(i2c_ctrl_pkg::LAST_BIT -
                                             r_next.bitc)];
            i2c_ctrl_pkg::H_RACK:
              r_next.sda_oe = r_next.keep;
            i2c_ctrl_pkg::H_STOP:
              r_next.sda_oe = 1'b1;
            default:
              r_next.sda_oe = 1'b0;
          endcase
        end
        else if ((r_next.st == i2c_ctrl_pkg::H_STOP) &&
                 (r_next.q == i2c_ctrl_pkg::Q_LAST))
        begin
          r_next.sda_oe = 1'b0;
        end
      end
    endcase
  end

  // host state
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      r_reg <= '0;
      r_reg.st <= i2c_ctrl_pkg::H_IDLE;
      r_reg.scl <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign wr_ready_o = ((r_reg.st == i2c_ctrl_pkg::H_IDLE) && attn_s) ||
                      (r_reg.st == i2c_ctrl_pkg::H_WAIT);
  assign rd_data_o = r_reg.rd_data;
  assign rd_valid_o = r_reg.rd_valid;
  assign dev_reset_o = r_reg.dev_reset;
  assign link.ctrl_serial_clock = r_reg.scl;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = r_reg.sda_oe;
  assign link.rd_strap_n = i2c_ctrl_pkg::RD_STRAP_I2C;
  assign link.wr_strap_n = i2c_ctrl_pkg::WR_STRAP_I2C;
endmodule : i2c_host_port

/* File: tb/i2c_link_checker.sv */
`timescale 1ns/1ps
module i2c_link_checker (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ctrl_serial_clock,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic ctrl_serial_data_io,
  input wire logic host_attention_n,
  input wire logic rd_strap_n,
  input wire logic wr_strap_n
);
  logic scl_q, sda_q, first, rd;
  logic [3:0] cnt;
  logic [7:0] sh;
  wire logic scl = ctrl_serial_clock;
  wire logic sda = ctrl_serial_data_io;
  wire logic rise = scl & ~scl_q;
  wire logic start = scl & scl_q & sda_q & ~sda;
  wire logic stop = scl & scl_q & ~sda_q & sda;
  wire logic ack = rise & (cnt == 4'h8);

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  // bit position within the current byte
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first <= 1'b0;
      rd <= 1'b0;
      cnt <= 4'h0;
      sh <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start)
      begin
        cnt <= 4'h0;
        first <= 1'b1;
      end
      else if (rise)
      begin
        sh <= {sh[6:0], sda};
        cnt <= ack ? 4'h0 : cnt + 4'h1;
        first <= first & ~ack;
        rd <= (first && cnt == 4'h7) ? sda : rd;
      end
    end
  end

  property p_open_drain;
    (dev_sda_oe |-> !dev_sda_o) and (host_sda_oe |-> !host_sda_o);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data line driven high");
  property p_dev_hold;
    scl && scl_q |-> $stable(dev_sda_oe);
  endproperty
  a_dev_hold: assert property (p_dev_hold)
    else $error("device data moved while clock high");
  property p_start;
    start |-> !sda throughout (##[1:100] $fell(scl));
  endproperty
  a_start: assert property (p_start)
    else $error("start not followed by clock fall");
  property p_stop;
    stop |=> scl [*8];
  endproperty
  a_stop: assert property (p_stop)
    else $error("clock not idle after stop");
  property p_addr;
    ack && first |-> sh[7:1] == i2c_ctrl_pkg::DEV_ADDR;
  endproperty
  a_addr: assert property (p_addr)
    else $error("wrong address byte");
  property p_dev_ack;
    ack && (first || !rd) |-> !sda;
  endproperty
  a_dev_ack: assert property (p_dev_ack)
    else $error("device did not acknowledge");
  property p_host_ack;
    ack && !first && rd |-> sda == host_attention_n;
  endproperty
  a_host_ack: assert property (p_host_ack)
    else $error("host ack does not follow attention");
  property p_attn_rise;
    $rose(host_attention_n) |-> scl;
  endproperty
  a_attn_rise: assert property (p_attn_rise)
    else $error("attention rose outside clock high");
  property p_attn_hold;
    $rose(host_attention_n) |-> host_attention_n throughout (##[1:400] rise);
  endproperty
  a_attn_hold: assert property (p_attn_hold)
    else $error("attention fell before next clock rise");
  property p_strap;
    rd_strap_n == i2c_ctrl_pkg::RD_STRAP_I2C &&
      wr_strap_n == i2c_ctrl_pkg::WR_STRAP_I2C;
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap levels wrong");
endmodule : i2c_link_checker

/* File: tb/i2c_host_control_port_tb.sv */
`timescale 1ns/1ps
module i2c_host_control_port_tb;
  logic mclk_i = 1'b0;
  logic link_clk = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic tx_valid = 1'b0;
  logic wr_valid = 1'b0;
  logic wr_last = 1'b0;
  logic tx_ready, rx_valid, wr_ready, rd_valid, dev_reset;
  logic [7:0] rx_data, rd_data;
  logic [7:0] rxq[$];
  logic [7:0] rdq[$];
  logic [7:0] wr_tab[3] = '{8'ha5, 8'h3c, 8'h81};
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int rst_cnt = 0;
  int i;

  i2c_link_if link ();
  i2c_dev_port i2c_dev_port_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .link_clk_i(link_clk), .link(link), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid));
  i2c_host_port i2c_host_port_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .link(link), .wr_data_i(wr_data), .wr_last_i(wr_last),
    .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .dev_reset_o(dev_reset));
  i2c_link_checker i2c_link_checker_inst (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .ctrl_serial_clock(link.ctrl_serial_clock),
    .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .ctrl_serial_data_io(link.ctrl_serial_data_io),
    .host_attention_n(link.host_attention_n),
    .rd_strap_n(link.rd_strap_n), .wr_strap_n(link.wr_strap_n));

  // core and link clocks
  initial
  begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  initial
  begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  // byte collection and hang guard
  always @(negedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1)
      rxq.push_back(rx_data);
    if (rd_valid === 1'b1)
      rdq.push_back(rd_data);
    if (dev_reset === 1'b1)
      rst_cnt++;
    if (cyc == 40000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      error_cnt++;
  endtask : check

  task automatic host_write(input logic [7:0] d, input logic last);
    @(posedge mclk_i);
    wr_data <= d;
    wr_last <= last;
    wr_valid <= 1'b1;
    @(negedge mclk_i);
    while (wr_ready !== 1'b1)
      @(negedge mclk_i);
    @(posedge mclk_i);
    wr_valid <= 1'b0;
  endtask : host_write

  task automatic dev_push(input logic [7:0] d);
    @(posedge mclk_i);
    tx_data <= d;
    tx_valid <= 1'b1;
    @(negedge mclk_i);
    while (tx_ready !== 1'b1)
      @(negedge mclk_i);
    @(posedge mclk_i);
    tx_valid <= 1'b0;
  endtask : dev_push

  task automatic settle(input int n);
    while (rxq.size() + rdq.size() < n)
      @(negedge mclk_i);
  endtask : settle

  task automatic report_and_stop();
    $display("compares %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // write, read, null-led read, late message after the last byte
  initial
  begin
    repeat (24) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (80) @(posedge mclk_i);
    for (i = 0; i < 3; i++)
      host_write(wr_tab[i], i == 2);
    settle(3);
    for (i = 0; i < 3; i++)
      check(rxq[i], wr_tab[i]);
    dev_push(8'h5a);
    dev_push(8'hc3);
    @(negedge mclk_i);
    check({7'h00, link.host_attention_n}, 8'h00);
    settle(5);
    check(rdq[0], 8'h5a);
    check(rdq[1], 8'hc3);
    check({7'h00, link.host_attention_n}, 8'h01);
    dev_push(8'h00);
    dev_push(8'h77);
    @(posedge link.host_attention_n);
    dev_push(8'h99);
    @(negedge link.host_attention_n);
    check({7'h00, link.ctrl_serial_clock}, 8'h01);
    settle(7);
    repeat (400) @(posedge mclk_i);
    check(rdq[2], 8'h77);
    check(rdq[3], 8'h99);
    check(8'(rdq.size()), 8'h04);
    check(8'(rst_cnt), 8'h00);
    report_and_stop();
  end
endmodule : i2c_host_control_port_tb
